// *** rtl/bsi_bank_decoder.sv ***
// Decoder and executor of the bank select instruction with its skip handling.
//
// How it works
// RULE1 - A word 0000 0001 1nnn copies the three-bit field nnn into pointer bits 6:4; the smaller variant puts nnn bits 2:1 in bits 6:5 and clears bit 7.
// RULE2 - Pointer bits 6:4 leave the block as the bank number, and every value 0 through 7 is accepted.
// RULE3 - Program tools reduce the 8-bit source address to its three high bits, so only nnn reaches here.
// RULE4 - On the smaller variant, pointer bits 4:0 are kept as they were.
// RULE5 - On the larger variant, pointer bit 7 and bits 3:0 are kept as they were.
// RULE6 - On the larger variant bit 7 picks the bank block and software changes it by bit writes to file 04.
// RULE7 - A taken skip in front of a bank word skips the bank word and the following word, three cycles in all.
// RULE8 - A run of bank words after a taken skip is skipped whole plus one more word, one cycle each.
// RULE9 - Programs are advised to use skip plus bank for far conditional jumps, with care over blocks.
// RULE10 - The bank word takes one cycle and changes no status flag.
`timescale 1ns/1ps
module bsi_bank_decoder #(
    parameter int VARIANT = bsi_pkg::BSI_VARIANT_SMALL
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire bsi_pkg::bsi_issue_t issue,
    input wire bsi_pkg::bsi_file_wr_t file_wr,
    output logic [bsi_pkg::BSI_DATA_W-1:0] pointer_value,
    output logic [bsi_pkg::BSI_BANK_W-1:0] bank_number,
    output logic block_select,
    output logic squash,
    output logic bank_exec,
    output logic status_write
);
    import bsi_pkg::*;

    localparam logic [BSI_DATA_W-1:0] KEEP_MASK = (VARIANT == BSI_VARIANT_LARGE) ?
        BSI_LARGE_KEEP :
        BSI_SMALL_KEEP;
    localparam logic [BSI_DATA_W-1:0] BANK_MASK = BSI_DATA_W'(((1 << BSI_BANK_W) - 1) << BSI_BANK_LSB);

    // Variants other than the two known ones, or field constants that do not fit the word, are refused.
    initial begin
        if (VARIANT != BSI_VARIANT_SMALL && VARIANT != BSI_VARIANT_LARGE) begin
            $error("bsi_bank_decoder: VARIANT must be 0 or 1");
        end
        if (BSI_PREFIX_LSB != BSI_BANK_W) begin
            $error("bsi_bank_decoder: the immediate field must sit just below the prefix");
        end
        if (BSI_PREFIX_LSB + $bits(BSI_BANK_PREFIX) != BSI_WORD_W) begin
            $error("bsi_bank_decoder: prefix and immediate must fill the instruction word");
        end
        if (BSI_BANK_LSB + BSI_BANK_W > BSI_DATA_W) begin
            $error("bsi_bank_decoder: the bank field must fit inside the pointer");
        end
        if (BSI_BLOCK_BIT >= BSI_DATA_W) begin
            $error("bsi_bank_decoder: the block bit must fit inside the pointer");
        end
        if (BSI_BLOCK_BIT >= BSI_BANK_LSB && BSI_BLOCK_BIT < BSI_BANK_LSB + BSI_BANK_W) begin
            $error("bsi_bank_decoder: the block bit must lie outside the bank field");
        end
        if ((~BSI_LARGE_KEEP) != BANK_MASK) begin
            $error("bsi_bank_decoder: the large variant must load exactly the bank field");
        end
    end

    // All decoder state except the pointer register in u_pointer lives in one struct that is registered in one place.
    typedef struct packed {
        bsi_state_t fsm;
        logic [BSI_DATA_W-1:0] shadow;
        logic squash;
        logic bank_exec;
        logic block_sel;
        logic status_wr;
    } bsi_dec_state_t;

    bsi_dec_state_t state_reg;
    bsi_dec_state_t state_next;

    logic is_bank;
    logic executes;
    logic ptr_wr;
    logic file_hit;
    logic [BSI_DATA_W-1:0] merged;
    logic [BSI_DATA_W-1:0] ptr_data;
    logic [BSI_DATA_W-1:0] ptr_q;
    logic [BSI_DATA_W-1:0] bank_field;

    // RULE1 opcode match
    assign is_bank = (issue.word[BSI_WORD_W-1:BSI_PREFIX_LSB] == BSI_BANK_PREFIX);
    assign bank_field = BSI_DATA_W'(issue.word[BSI_BANK_W-1:0]) << BSI_BANK_LSB;

    // RULE6 pointer file write
    // Bit set and bit clear on the pointer reach it through this general file write path.
    assign file_hit = file_wr.wr && (file_wr.addr == BSI_POINTER_OFFSET);

    // RULE4 RULE5 per-bit merge
    // Each pointer bit either keeps its old value or takes the bank field, as the variant's keep mask says.
    for (genvar b = 0; b < BSI_DATA_W; b++) begin : g_merge
        if (KEEP_MASK[b]) begin : g_keep
            assign merged[b] = state_reg.shadow[b];
        end else begin : g_load
            assign merged[b] = bank_field[b];
        end
    end

    // Skip timing, one word per cycle, is as follows.
    // In cycle 0 a word whose skip is taken executes and arms the skip state.
    // In cycle 1 the next word is dropped, and squash shows it one cycle later.
    // When that dropped word is a bank word the skip state holds, so the word in cycle 2 is dropped too.
    // A run of bank words keeps the skip state alive, and the first word of another kind ends it.
    // A dropped word never writes the pointer, whatever it encodes.
    // The shadow copy lets the merge see the old pointer in the cycle in which the write is decided.
    always_comb begin
        state_next = state_reg;
        state_next.squash = 1'b0;
        state_next.bank_exec = 1'b0;
        // RULE10 no flag change
        state_next.status_wr = 1'b0;
        executes = 1'b0;
        ptr_wr = 1'b0;
        ptr_data = state_reg.shadow;
        if (issue.valid) begin
            case (state_reg.fsm)
                BSI_RUN: begin
                    // A word issued in the run state executes, and its own taken skip arms the skip state.
                    executes = 1'b1;
                    if (issue.skip_taken) begin
                        state_next.fsm = BSI_SKIP;
                    end else begin
                        state_next.fsm = BSI_RUN;
                    end
                end
                BSI_SKIP: begin
                    // RULE7 skip bank and next
                    state_next.squash = 1'b1;
                    // RULE8 stay in skip over runs
                    // A dropped bank word does not end the skip, so the word after the run is dropped as well.
                    if (!is_bank) begin
                        state_next.fsm = BSI_RUN;
                    end else begin
                        state_next.fsm = BSI_SKIP;
                    end
                end
                default: begin
                    state_next.fsm = BSI_RUN;
                end
            endcase
        end
        // An executed bank word wins over a file write in the same cycle, and that write is lost.
        if (executes && is_bank) begin
            // RULE4 RULE5 keep other bits
            ptr_data = merged;
            ptr_wr = 1'b1;
            // RULE10 single cycle
            state_next.bank_exec = 1'b1;
        end else if (file_hit) begin
            // RULE6 software bit writes
            ptr_data = file_wr.data;
            ptr_wr = 1'b1;
        end
        if (ptr_wr) begin
            state_next.shadow = ptr_data;
        end
        // RULE6 block bit follows pointer
        state_next.block_sel = (VARIANT == BSI_VARIANT_LARGE) ? state_next.shadow[BSI_BLOCK_BIT] : 1'b0;
    end

    // Reset puts the core in the run state with the pointer cleared.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg.fsm <= BSI_RUN;
            state_reg.shadow <= BSI_POINTER_RESET;
            state_reg.squash <= 1'b0;
            state_reg.bank_exec <= 1'b0;
            state_reg.block_sel <= 1'b0;
            state_reg.status_wr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    bsi_pointer_reg #(
        .WIDTH(BSI_DATA_W)
    ) u_pointer (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .wr_en(ptr_wr),
        .wr_data(ptr_data),
        .rd_data(ptr_q)
    );

    // Every output below comes straight from a flip-flop.
    assign pointer_value = ptr_q;
    // RULE2 bank number out
    assign bank_number = ptr_q[BSI_BANK_LSB+BSI_BANK_W-1:BSI_BANK_LSB];
    assign block_select = state_reg.block_sel;
    assign squash = state_reg.squash;
    assign bank_exec = state_reg.bank_exec;
    // RULE10 no flag change
    assign status_write = state_reg.status_wr;
endmodule : bsi_bank_decoder

// *** common/bsi_pkg.sv ***
// Package with constants and carrier types for the bank select instruction decoder.
package bsi_pkg;
    localparam int BSI_WORD_W = 12;
    localparam int BSI_DATA_W = 8;
    // Fixed nine-bit prefix of the bank instruction: 0000 0001 1.
    localparam logic [8:0] BSI_BANK_PREFIX = 9'h003;
    localparam int BSI_PREFIX_LSB = 3;
    localparam int BSI_BANK_LSB = 4;
    localparam int BSI_BANK_W = 3;
    localparam int BSI_BLOCK_BIT = 7;
    localparam logic [7:0] BSI_POINTER_OFFSET = 8'h04;
    localparam logic [7:0] BSI_POINTER_RESET = 8'h00;
    // Variant codes: 0 is the smaller device, 1 the larger one.
    localparam int BSI_VARIANT_SMALL = 0;
    localparam int BSI_VARIANT_LARGE = 1;
    localparam logic [7:0] BSI_SMALL_KEEP = 8'h1f;
    localparam logic [7:0] BSI_LARGE_KEEP = 8'h8f;

    typedef enum logic [1:0] {
        BSI_RUN = 2'b01,
        BSI_SKIP = 2'b10
    } bsi_state_t;

    typedef struct packed {
        logic valid;
        logic [BSI_WORD_W-1:0] word;
        logic skip_taken;
    } bsi_issue_t;

    typedef struct packed {
        logic wr;
        logic [BSI_DATA_W-1:0] addr;
        logic [BSI_DATA_W-1:0] data;
    } bsi_file_wr_t;
endpackage : bsi_pkg

// *** rtl/bsi_pointer_reg.sv ***
// Holding register for the indirect file pointer with a registered read port.
`timescale 1ns/1ps
module bsi_pointer_reg #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic [WIDTH-1:0] rd_data
);
    import bsi_pkg::*;

    initial begin
        if (WIDTH != BSI_DATA_W) begin
            $error("bsi_pointer_reg: WIDTH must equal the data width");
        end
    end

    typedef struct packed {
        logic [WIDTH-1:0] value;
    } bsi_preg_state_t;

    bsi_preg_state_t state_reg;
    bsi_preg_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (wr_en) begin
            state_next.value = wr_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rd_data = state_reg.value;
endmodule : bsi_pointer_reg

// *** verif/bsi_chk.sv ***
// Port checker for the bank select decoder.
`timescale 1ns/1ps
module bsi_chk #(parameter int VARIANT = 0) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire bsi_pkg::bsi_issue_t issue,
    input wire bsi_pkg::bsi_file_wr_t file_wr,
    input wire logic [7:0] pointer_value,
    input wire logic [2:0] bank_number,
    input wire logic block_select,
    input wire logic squash,
    input wire logic bank_exec,
    input wire logic status_write
);
    import bsi_pkg::*;
    localparam logic [7:0] KEEP = VARIANT ? BSI_LARGE_KEEP : BSI_SMALL_KEEP;
    wire logic bk = issue.valid && issue.word[11:3] == BSI_BANK_PREFIX;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_skip_bank;
        issue.valid && issue.skip_taken && !bk ##1 bk ##1 issue.valid;
    endsequence
    chk_bank_load: assert property (bank_exec |-> bank_number == $past(issue.word[2:0]))
        else $error("load");
    chk_bank_num: assert property (bank_number == pointer_value[6:4]) else $error("bank");
    chk_keep_bits: assert property (bank_exec |-> ((pointer_value ^ $past(pointer_value)) & KEEP) == 8'h00)
        else $error("keep");
    chk_block_bit: assert property (block_select == (VARIANT != 0 && pointer_value[7])) else $error("block");
    chk_skip_pair: assert property (s_skip_bank |-> squash [*2]) else $error("pair");
    chk_skip_run: assert property (squash && $past(bk) && issue.valid |=> squash) else $error("run");
    chk_one_cycle: assert property (bk |=> bank_exec ^ squash) else $error("cycle");
    chk_no_flags: assert property (!status_write) else $error("flags");
endmodule : bsi_chk
bind bsi_bank_decoder bsi_chk #(.VARIANT(VARIANT)) chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .issue(issue),
    .file_wr(file_wr), .pointer_value(pointer_value), .bank_number(bank_number), .block_select(block_select),
    .squash(squash), .bank_exec(bank_exec), .status_write(status_write));

// *** verif/bsi_bank_decoder_tb.sv ***
// Self-checking bench for the bank select decoder.
`timescale 1ns/1ps
module bsi_bank_decoder_tb;
    import bsi_pkg::*;
    logic sys_clk = 0;
    logic rst_b = 0;
    bsi_issue_t issue = '0;
    bsi_file_wr_t file_wr = '0;
    logic [7:0] pv;
    logic sq;
    logic [2:0] bn;
    logic bs;
    logic be;
    logic sw;
    int mismatches = 0;
    int comparisons = 0;
    bsi_bank_decoder #(.VARIANT(1)) uut (.sys_clk(sys_clk), .rst_b(rst_b), .issue(issue), .file_wr(file_wr),
        .pointer_value(pv), .bank_number(bn), .block_select(bs), .squash(sq), .bank_exec(be), .status_write(sw));
    always #12.5 sys_clk = ~sys_clk;
    task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    task automatic step(logic [11:0] w, logic k);
        issue = '{1'b1, w, k};
        @(negedge sys_clk);
    endtask : step
    task automatic wr_ptr(logic [7:0] d);
        issue = '0;
        file_wr = '{1'b1, BSI_POINTER_OFFSET, d};
        @(negedge sys_clk);
        file_wr = '0;
    endtask : wr_ptr
    task automatic t_bank();
        logic [7:0] e = 8'hff;
        wr_ptr(e);
        for (int a = 0; a < 256; a += 32) begin
            step({BSI_BANK_PREFIX, a[7:5]}, 1'b0);
            e = e & BSI_LARGE_KEEP | {1'b0, a[7:5], 4'h0};
            cmp("pointer", e, pv);
            cmp("bank_number", {5'h0, a[7:5]}, {5'h0, bn});
            cmp("block_select", 8'h01, {7'h0, bs});
            cmp("bank_exec", 8'h01, {7'h0, be});
            cmp("status_write", 8'h00, {7'h0, sw});
        end
    endtask : t_bank
    task automatic t_block();
        wr_ptr(8'h7f);
        cmp("block_select", 8'h00, {7'h0, bs});
        step({BSI_BANK_PREFIX, 3'h5}, 1'b0);
        cmp("pointer", 8'h5f, pv);
        cmp("block_select", 8'h00, {7'h0, bs});
        wr_ptr(8'hdf);
        cmp("block_select", 8'h01, {7'h0, bs});
        cmp("bank_number", 8'h05, {5'h0, bn});
        wr_ptr(8'hff);
        cmp("pointer", 8'hff, pv);
    endtask : t_block
    task automatic t_skip();
        for (int r = 0; r < 4; r++) begin
            step(12'h700, 1'b1);
            cmp("squash", 8'h00, {7'h0, sq});
            repeat (r) begin
                step({BSI_BANK_PREFIX, 3'h2}, 1'b0);
                cmp("squash", 8'h01, {7'h0, sq});
                cmp("bank_exec", 8'h00, {7'h0, be});
            end
            step(12'h700, 1'b0);
            cmp("squash", 8'h01, {7'h0, sq});
        end
        step(12'h700, 1'b0);
        cmp("squash", 8'h00, {7'h0, sq});
        cmp("pointer", 8'hff, pv);
    endtask : t_skip
    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_b = 1;
        cmp("reset", BSI_POINTER_RESET, pv);
        t_bank();
        t_block();
        t_skip();
        finish_test();
    end
    initial begin
        #20us;
        mismatches++;
        finish_test();
    end
endmodule : bsi_bank_decoder_tb
